/* File: core/port_e_fs_pkg.sv */
// Package with constants and types for the port E function select block.
// Notes on behaviour
// - Function select register decodes at offset 0x000A from the block base.
// - Reads are allowed any time while the register is in the on-chip map.
// - A selected bus control function overrides that pin's direction bit.
// - Normal single-chip reset: all general I/O, E clock disable set.
// - Normal expanded reset: all select bits clear, so E clock and free-cycle active.
// - Special test and emulation reset enable queue, E clock, strobe, read/write.
// - Expanded and peripheral modes remove the register from the map.
// - Free-cycle select: write once normal, never emulation, anytime special.
// - Free-cycle select zero drives free-cycle indication on pin 7.
// - Queue status select drives pins 6:5; same write rights as free-cycle.
// - Single-chip and peripheral modes ignore free-cycle, queue and read/write selects.
// - E clock disable writable anytime in normal and special, never emulation.
// - E clock disable zero drives E clock on pin 4, else general I/O.
// - Strobe select drives low-byte strobe on pin 3; write once normal.
// - With debug tagging, tag at rising E edge, strobe at falling edge.
// - Strobe select ignored in single-chip, peripheral and normal narrow modes.
// - External reads may drive all sixteen data bits without the strobe.
// - Read/write select drives read/write on pin 2; write once normal.
// - Operating mode comes from mode register bits 7:5.
package port_e_fs_pkg;

	localparam logic [7:0] FSEL_ADDR = 8'h0A;
	localparam int FREE_BIT = 7;
	localparam int QUEUE_BIT = 5;
	localparam int BUS_E_CLOCK_BIT = 4;
	localparam int STRB_BIT = 3;
	localparam int RW_BIT = 2;
	localparam logic [7:0] FSEL_IMPL_MASK = 8'hBC;

	localparam logic [7:0] RST_SPECIAL_SC = 8'h00;
	localparam logic [7:0] RST_SPECIAL_TEST = 8'h2C;
	localparam logic [7:0] RST_PERIPH = 8'h00;
	localparam logic [7:0] RST_EMUL = 8'hAC;
	localparam logic [7:0] RST_NORMAL_SC = 8'h10;
	localparam logic [7:0] RST_NORMAL_EXP = 8'h00;

	typedef enum logic [2:0] {
		MODE_SPECIAL_SC = 3'b000,
		MODE_EMUL_NARROW = 3'b001,
		MODE_SPECIAL_TEST = 3'b010,
		MODE_EMUL_WIDE = 3'b011,
		MODE_NORMAL_SC = 3'b100,
		MODE_NORMAL_NARROW = 3'b101,
		MODE_PERIPH = 3'b110,
		MODE_NORMAL_WIDE = 3'b111
	} op_mode_t;

	typedef struct packed {
		logic free_cycle;
		logic queue_hi;
		logic queue_lo;
		logic bus_e_clock;
		logic low_strobe;
		logic read_write;
	} bus_ctrl_t;

endpackage : port_e_fs_pkg

/* File: core/port_e_function_select.sv */
// Port E function select register and pin multiplexer.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/10ps
module port_e_function_select (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [0:0] sel_i,
	input wire logic [7:0] dat_i,
	output logic [7:0] dat_o,
	output logic ack_o,
	output logic external_cycle_o,
	input wire logic [2:0] mode_select_i,
	input wire logic tag_enable_i,
	input wire logic low_tag_signal_i,
	input wire port_e_fs_pkg::bus_ctrl_t ctrl_i,
	input wire logic [7:2] port_e_direction_i,
	input wire logic [7:2] port_e_data_i,
	output logic [7:2] port_e_pins_o,
	output logic [7:2] port_e_pins_oe_o,
	output logic [7:0] port_e_function_select_o
);

	////////////////////////////////////////////////////////////////////////////
	port_e_fs_pkg::op_mode_t mode;
	logic [7:0] fsel_reg;
	logic [7:0] fsel_next;
	logic [7:0] lock_reg;
	logic ack_reg;
	logic [7:0] dat_reg;
	logic ext_reg;
	logic in_map;
	logic hit;
	logic wr_fire;
	logic is_emul;
	logic is_special;
	logic is_normal;
	logic ctl_active;
	logic strb_active;
	logic [7:2] alt_en;
	logic [7:2] alt_val;
	logic bus_e_clock_q;
	logic strobe_q;

	assign mode = port_e_fs_pkg::op_mode_t'(mode_select_i);
	assign is_emul = (mode == port_e_fs_pkg::MODE_EMUL_NARROW) ||
		(mode == port_e_fs_pkg::MODE_EMUL_WIDE);
	assign is_special = (mode == port_e_fs_pkg::MODE_SPECIAL_SC) ||
		(mode == port_e_fs_pkg::MODE_SPECIAL_TEST) ||
		(mode == port_e_fs_pkg::MODE_PERIPH);
	assign is_normal = !is_emul && !is_special;

	// Expanded modes and peripheral mode push the access onto the external bus.
	function automatic logic reg_in_map(input port_e_fs_pkg::op_mode_t m);
		case (m)
			port_e_fs_pkg::MODE_SPECIAL_SC: reg_in_map = 1'b1;
			port_e_fs_pkg::MODE_SPECIAL_TEST: reg_in_map = 1'b1;
			port_e_fs_pkg::MODE_NORMAL_SC: reg_in_map = 1'b1;
			default: reg_in_map = 1'b0;
		endcase
	endfunction : reg_in_map

	function automatic logic [7:0] reset_value(input port_e_fs_pkg::op_mode_t m);
		case (m)
			port_e_fs_pkg::MODE_SPECIAL_SC: reset_value = port_e_fs_pkg::RST_SPECIAL_SC;
			port_e_fs_pkg::MODE_SPECIAL_TEST: reset_value = port_e_fs_pkg::RST_SPECIAL_TEST;
			port_e_fs_pkg::MODE_PERIPH: reset_value = port_e_fs_pkg::RST_PERIPH;
			port_e_fs_pkg::MODE_EMUL_NARROW: reset_value = port_e_fs_pkg::RST_EMUL;
			port_e_fs_pkg::MODE_EMUL_WIDE: reset_value = port_e_fs_pkg::RST_EMUL;
			port_e_fs_pkg::MODE_NORMAL_SC: reset_value = port_e_fs_pkg::RST_NORMAL_SC;
			default: reset_value = port_e_fs_pkg::RST_NORMAL_EXP;
		endcase
	endfunction : reset_value

	assign in_map = reg_in_map(mode);
	assign hit = cyc_i && stb_i && (adr_i == port_e_fs_pkg::FSEL_ADDR);
	assign wr_fire = hit && we_i && sel_i[0] && in_map && !ack_reg;

	////////////////////////////////////////////////////////////////////////////
	// Write rights per bit; the E clock disable is never write once.
	always_comb begin
		fsel_next = fsel_reg;
		for (int i = 0; i < 8; i++) begin
			if (port_e_fs_pkg::FSEL_IMPL_MASK[i] && !is_emul) begin
				if (is_special || i == port_e_fs_pkg::BUS_E_CLOCK_BIT || !lock_reg[i]) begin
					fsel_next[i] = dat_i[i];
				end
			end
		end
		fsel_next = fsel_next & port_e_fs_pkg::FSEL_IMPL_MASK;
	end

	// The mode is sampled while reset is held, so it must be stable by then.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fsel_reg <= reset_value(mode);
		end else if (wr_fire) begin
			fsel_reg <= fsel_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_reg <= 8'h00;
		end else if (wr_fire && is_normal) begin
			lock_reg <= lock_reg | port_e_fs_pkg::FSEL_IMPL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One wait-free answer per request; ack drops for a cycle between requests.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 8'h00;
			ext_reg <= 1'b0;
		end else begin
			ack_reg <= cyc_i && stb_i && !ack_reg;
			ext_reg <= hit && !in_map && !ack_reg;
			if (hit && !we_i && in_map && !ack_reg) begin
				dat_reg <= fsel_reg;
			end else if (cyc_i && stb_i && !ack_reg) begin
				dat_reg <= 8'h00;
			end
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;
	assign external_cycle_o = ext_reg;
	assign port_e_function_select_o = fsel_reg;

	////////////////////////////////////////////////////////////////////////////
	// Pin multiplexer.
	assign ctl_active = (mode != port_e_fs_pkg::MODE_SPECIAL_SC) &&
		(mode != port_e_fs_pkg::MODE_NORMAL_SC) &&
		(mode != port_e_fs_pkg::MODE_PERIPH);
	assign strb_active = ctl_active && (mode != port_e_fs_pkg::MODE_NORMAL_NARROW);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_e_clock_q <= 1'b0;
			strobe_q <= 1'b1;
		end else begin
			bus_e_clock_q <= ctrl_i.bus_e_clock;
			if (tag_enable_i && ctrl_i.bus_e_clock && !bus_e_clock_q) begin
				strobe_q <= low_tag_signal_i;
			end else if (!tag_enable_i || (!ctrl_i.bus_e_clock && bus_e_clock_q)) begin
				strobe_q <= ctrl_i.low_strobe;
			end
		end
	end

	always_comb begin
		alt_en = 6'h00;
		alt_val = 6'h00;
		alt_en[7] = ctl_active && !fsel_reg[port_e_fs_pkg::FREE_BIT];
		alt_val[7] = ctrl_i.free_cycle;
		alt_en[6] = ctl_active && fsel_reg[port_e_fs_pkg::QUEUE_BIT];
		alt_en[5] = alt_en[6];
		alt_val[6] = ctrl_i.queue_hi;
		alt_val[5] = ctrl_i.queue_lo;
		alt_en[4] = !fsel_reg[port_e_fs_pkg::BUS_E_CLOCK_BIT];
		alt_val[4] = ctrl_i.bus_e_clock;
		alt_en[3] = strb_active && fsel_reg[port_e_fs_pkg::STRB_BIT];
		alt_val[3] = strobe_q;
		alt_en[2] = ctl_active && fsel_reg[port_e_fs_pkg::RW_BIT];
		alt_val[2] = ctrl_i.read_write;
	end

	// Selected control functions override the direction bit.
	// The data bus lies outside this block, so reads never depend on the strobe pin.
	generate
		for (genvar g = 2; g < 8; g++) begin : g_pin
			assign port_e_pins_o[g] = alt_en[g] ? alt_val[g] : port_e_data_i[g];
			assign port_e_pins_oe_o[g] = alt_en[g] | port_e_direction_i[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	property p_reserved_zero;
		@(posedge clk_i) disable iff (rst_i)
		(fsel_reg & ~port_e_fs_pkg::FSEL_IMPL_MASK) == 8'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_emul_no_write;
		@(posedge clk_i) disable iff (rst_i)
		(is_emul && wr_fire) |=> $stable(fsel_reg);
	endproperty
	a_emul_no_write: assert property (p_emul_no_write) else $error("emulation write");

	property p_once_lock;
		@(posedge clk_i) disable iff (rst_i)
		(is_normal && wr_fire && lock_reg[port_e_fs_pkg::RW_BIT]) |=>
			$stable(fsel_reg[port_e_fs_pkg::RW_BIT]);
	endproperty
	a_once_lock: assert property (p_once_lock) else $error("write once broken");

	property p_bus_e_clock_anytime;
		@(posedge clk_i) disable iff (rst_i)
		(is_normal && wr_fire) |=>
			fsel_reg[port_e_fs_pkg::BUS_E_CLOCK_BIT] == $past(dat_i[port_e_fs_pkg::BUS_E_CLOCK_BIT]);
	endproperty
	a_bus_e_clock_anytime: assert property (p_bus_e_clock_anytime) else $error("bus_e_clock bit not written");

	property p_bus_e_clock_pin;
		@(posedge clk_i) disable iff (rst_i)
		!fsel_reg[port_e_fs_pkg::BUS_E_CLOCK_BIT] |->
			port_e_pins_oe_o[4] && port_e_pins_o[4] == ctrl_i.bus_e_clock;
	endproperty
	a_bus_e_clock_pin: assert property (p_bus_e_clock_pin) else $error("bus_e_clock pin wrong");

	property p_sc_ignore;
		@(posedge clk_i) disable iff (rst_i)
		(mode == port_e_fs_pkg::MODE_NORMAL_SC && !port_e_direction_i[2]) |->
			!port_e_pins_oe_o[2];
	endproperty
	a_sc_ignore: assert property (p_sc_ignore) else $error("rw driven in single chip");

	property p_narrow_strobe;
		@(posedge clk_i) disable iff (rst_i)
		(mode == port_e_fs_pkg::MODE_NORMAL_NARROW && !port_e_direction_i[3]) |->
			!port_e_pins_oe_o[3];
	endproperty
	a_narrow_strobe: assert property (p_narrow_strobe) else $error("strobe in narrow");

	sequence s_read_req;
		cyc_i && stb_i && !we_i && !ack_reg && hit && in_map;
	endsequence

	property p_read_data;
		@(posedge clk_i) disable iff (rst_i)
		s_read_req |=> ack_o && dat_o == $past(fsel_reg);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data wrong");

	property p_reset_nsc;
		@(posedge clk_i)
		(rst_i && mode == port_e_fs_pkg::MODE_NORMAL_SC) |=>
			fsel_reg == port_e_fs_pkg::RST_NORMAL_SC;
	endproperty
	a_reset_nsc: assert property (p_reset_nsc) else $error("reset value wrong");

	property p_ext_cycle;
		@(posedge clk_i) disable iff (rst_i)
		(hit && !in_map && !ack_reg) |=> external_cycle_o && $stable(fsel_reg);
	endproperty
	a_ext_cycle: assert property (p_ext_cycle) else $error("external cycle missing");

endmodule : port_e_function_select

/* File: testbench/ext_bus_model.sv */
// Model of the external bus devices that watch the port E pins.
`timescale 1ns/10ps
module ext_bus_model (
	input wire logic clk_i,
	input wire logic [7:2] pins_i,
	input wire logic [7:2] oe_i,
	output logic [7:2] level_o
);
	logic [7:2] last_reg;
	////////////////////////////////////////////////////////////////////////////////
	// An undriven pin shows the inverse of its last level, so a stale value never passes.
	always_comb begin
		for (int i = 2; i < 8; i++) begin
			level_o[i] = oe_i[i] ? pins_i[i] : ~last_reg[i];
		end
	end
	always_ff @(posedge clk_i) begin
		last_reg <= level_o;
	end
endmodule : ext_bus_model

/* File: testbench/port_e_function_select_test.sv */
// Self-checking testbench for the port E function select block.
`timescale 1ns/10ps
module port_e_function_select_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [0:0] sel_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [7:0] dat_i = 8'h00;
	logic [7:0] dat_o, fsel_o, rd;
	logic ack_o, ext_o, ext, in_map;
	logic [2:0] mode_i = 3'b100;
	port_e_fs_pkg::bus_ctrl_t ctrl_i = 6'b101011;
	logic [7:2] dir_i = 6'h00;
	logic [7:2] data_i = 6'h00;
	logic [7:2] pins_o, oe_o, level;
	int err_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #50 clk_i = ~clk_i;
	port_e_function_select uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.external_cycle_o(ext_o), .mode_select_i(mode_i), .tag_enable_i(1'b0),
		.low_tag_signal_i(1'b0), .ctrl_i(ctrl_i), .port_e_direction_i(dir_i),
		.port_e_data_i(data_i), .port_e_pins_o(pins_o), .port_e_pins_oe_o(oe_o),
		.port_e_function_select_o(fsel_o));
	ext_bus_model model (.clk_i(clk_i), .pins_i(pins_o), .oe_i(oe_o), .level_o(level));
	////////////////////////////////////////////////////////////////////////////////
	task end_of_test;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// The master holds the request until it samples ack high, giving up after 20 cycles.
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		rd = dat_o;
		ext = ext_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task do_reset(input logic [2:0] m, input int n);
		rst_i <= 1'b1;
		mode_i <= m;
		repeat (n) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask : do_reset
	function logic [7:0] rst_val(input logic [2:0] m);
		case (m)
			3'b001, 3'b011: return 8'hAC;
			3'b010: return 8'h2C;
			3'b100: return 8'h10;
			default: return 8'h00;
		endcase
	endfunction : rst_val
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 5000) begin
			err_count++;
			end_of_test;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset(3'b100, 12);
		for (int m = 0; m < 8; m++) begin
			do_reset(m[2:0], 2);
			in_map = (m == 0 || m == 2 || m == 4);
			chk(fsel_o, rst_val(m[2:0]));
			wb(1'b0, 8'h0A, 8'h00);
			chk({7'h00, ext}, {7'h00, ~in_map});
			chk(rd, in_map ? rst_val(m[2:0]) : 8'h00);
		end
		// Normal single-chip: the first write locks the write-once bits.
		do_reset(3'b100, 2);
		wb(1'b1, 8'h0A, 8'hFF);
		chk(fsel_o, 8'hBC);
		wb(1'b1, 8'h0A, 8'h00);
		chk(fsel_o, 8'hAC);
		chk({2'b00, oe_o}, 8'h04);
		chk({7'h00, level[4]}, {7'h00, ctrl_i.bus_e_clock});
		dir_i <= 6'b101001;
		data_i <= 6'b110101;
		@(posedge clk_i);
		chk({2'b00, oe_o}, 8'h2D);
		chk({2'b00, level & 6'b101001}, 8'h21);
		wb(1'b0, 8'h03, 8'h00);
		chk(rd, 8'h00);
		// Special single-chip: bits stay writable after the first write.
		do_reset(3'b000, 2);
		wb(1'b1, 8'h0A, 8'hFF);
		wb(1'b1, 8'h0A, 8'h00);
		chk(fsel_o, 8'h00);
		// Special test: selected functions override the direction bits.
		dir_i <= 6'h00;
		do_reset(3'b010, 2);
		repeat (2) @(posedge clk_i);
		chk({2'b00, oe_o}, 8'h3F);
		chk({2'b00, level}, {2'b00, ctrl_i});
		wb(1'b1, 8'h0A, 8'h90);
		chk({2'b00, oe_o}, 8'h00);
		end_of_test;
	end
endmodule : port_e_function_select_test
